/* File: rtl/rfttc_pkg.sv */
// Purpose: Shared constants and types for the receiver test control register bank.
// Assumes: One 50 MHz core clock; registers reached by the serial control core.
// Notes:   Offsets are the byte addresses seen by the serial control core.
package rfttc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] SYNTH_RX_TEST_ENABLES_OFS = 8'h38;
  localparam logic [7:0] FILTER_CAL_TEST_OFS       = 8'h39;
  localparam logic [7:0] XTAL_TEST_CONTROL_OFS     = 8'h3A;

  localparam logic [7:0] SYNTH_RX_TEST_ENABLES_RST = 8'h00;
  localparam logic [7:0] FILTER_CAL_TEST_RST       = 8'h00;
  localparam logic [7:0] XTAL_TEST_CONTROL_RST     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL         = 8'h00;

  // Bits 3 and 0 of the synthesizer register are reserved.
  localparam logic [7:0] SYNTH_WRITE_MASK = 8'hF6;

  localparam int unsigned SYN_OSC_BIT    = 7;
  localparam int unsigned SYN_DIV_BIT    = 6;
  localparam int unsigned SYN_PHASE_BIT  = 5;
  localparam int unsigned SYN_CLK_BIT    = 4;
  localparam int unsigned SYN_VREF_BIT   = 2;
  localparam int unsigned SYN_RX_BIT     = 1;

  localparam int unsigned CAL_TRIG_BIT    = 7;
  localparam int unsigned CAL_INHIBIT_BIT = 6;
  localparam int unsigned CAL_ADJ_MSB     = 5;
  localparam int unsigned CAL_ADJ_LSB     = 4;
  localparam int unsigned CAL_MAN_MSB     = 3;
  localparam int unsigned CAL_MAN_LSB     = 0;

  localparam int unsigned XO_LEVEL_MSB    = 7;
  localparam int unsigned XO_LEVEL_LSB    = 5;
  localparam int unsigned XO_SINK_BIT     = 4;
  localparam int unsigned XO_OFFS_EN_BIT  = 3;
  localparam int unsigned XO_KICK_BIT     = 2;
  localparam int unsigned XO_DET_BIT      = 1;
  localparam int unsigned XO_BIAS_BIT     = 0;

  // Resistance reference shift in tenths of a percent, signed.
  localparam logic signed [7:0] R_SHIFT_NONE = 8'sh00;
  localparam logic signed [7:0] R_SHIFT_P125 = 8'sh7D;
  localparam logic signed [7:0] R_SHIFT_M62  = 8'shC2;
  localparam logic signed [7:0] R_SHIFT_M41  = 8'shD7;

  typedef enum logic [1:0] {
    RFTTC_ADJ_NONE = 2'b00,
    RFTTC_ADJ_P125 = 2'b01,
    RFTTC_ADJ_M62  = 2'b10,
    RFTTC_ADJ_M41  = 2'b11
  } rfttc_adjust_t;

  typedef struct packed {
    logic controlled_osc_enable;
    logic divider_enable;
    logic phase_detect_enable;
    logic synth_clock_enable;
    logic reference_voltage_enable;
    logic receiver_enable;
  } rfttc_synth_en_t;

  typedef struct packed {
    logic [2:0] xtal_offset_level;
    logic       xtal_offset_sink;
    logic       xtal_offset_source;
    logic       xtal_offset_enable;
    logic       xtal_kick_disable;
    logic       xtal_detector_disable;
    logic       xtal_bias_disable;
  } rfttc_xtal_ctl_t;

endpackage : rfttc_pkg

/* File: rtl/rfttc_cal_ctrl.sv */
// Purpose: Filter RC calibration request and reference shift for the test bank.
// Assumes: Write strobe and data come from the core clock domain.
// Notes:   Start pulse lasts one cycle; the shift output is registered.
`timescale 1ns/100ps
module rfttc_cal_ctrl (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              cal_wr_in,
  input  wire logic [7:0]        cal_data_in,
  output logic                   cal_start_out,
  output logic signed [7:0]      r_shift_out
);

  rfttc_pkg::rfttc_adjust_t adj;
  logic signed [7:0]        shift_d;

  assign adj = rfttc_pkg::rfttc_adjust_t'(cal_data_in[rfttc_pkg::CAL_ADJ_MSB:rfttc_pkg::CAL_ADJ_LSB]);

  always_comb begin
    case (adj)
      rfttc_pkg::RFTTC_ADJ_NONE: shift_d = rfttc_pkg::R_SHIFT_NONE;
      rfttc_pkg::RFTTC_ADJ_P125: shift_d = rfttc_pkg::R_SHIFT_P125;
      rfttc_pkg::RFTTC_ADJ_M62:  shift_d = rfttc_pkg::R_SHIFT_M62;
      default:                   shift_d = rfttc_pkg::R_SHIFT_M41;
    endcase
  end

  // A request carrying the inhibit bit in the same write is also blocked.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_start_out <= 1'b0;
    end else begin
      cal_start_out <= cal_wr_in && cal_data_in[rfttc_pkg::CAL_TRIG_BIT]
                       && !cal_data_in[rfttc_pkg::CAL_INHIBIT_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_shift_out <= rfttc_pkg::R_SHIFT_NONE;
    end else if (cal_wr_in) begin
      r_shift_out <= shift_d;
    end
  end

  a_start_needs_req : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cal_start_out |-> $past(cal_wr_in) && !$past(cal_data_in[rfttc_pkg::CAL_INHIBIT_BIT]))
    else $error("Calibration start without an allowed request.");

  a_shift_table_ok : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cal_wr_in && cal_data_in[5:4] == 2'b01 |=> r_shift_out == 8'sh7D)
    else $error("Adjust code 01 did not give the plus shift.");

endmodule : rfttc_cal_ctrl

/* File: rtl/rfttc_regs.sv */
// Purpose: Test control register bank for synthesizer, filter calibration and crystal oscillator.
// Assumes: The serial control core presents one-cycle read and write strobes on clk_in.
// Notes:   Read data appears one cycle after the read strobe; unmapped reads return zero.
`timescale 1ns/100ps
module rfttc_regs (
  input  wire logic                          clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic [rfttc_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic                          wr_en_in,
  input  wire logic                          rd_en_in,
  input  wire logic [rfttc_pkg::DATA_W-1:0]  wr_data_in,
  output logic      [rfttc_pkg::DATA_W-1:0]  rd_data_out,
  output rfttc_pkg::rfttc_synth_en_t         synth_en_out,
  output logic                               filter_cal_start_out,
  output logic                               filter_cal_inhibit_out,
  output logic signed [7:0]                  filter_cal_r_shift_out,
  output logic      [3:0]                    filter_cal_result_out,
  output rfttc_pkg::rfttc_xtal_ctl_t         xtal_ctl_out
);

  logic [7:0] synth_q;
  logic [7:0] cal_q;
  logic [7:0] xtal_q;
  logic       sel_synth;
  logic       sel_cal;
  logic       sel_xtal;
  logic [7:0] rd_data_d;

  always_comb begin
    sel_synth = 1'b0;
    sel_cal   = 1'b0;
    sel_xtal  = 1'b0;
    if (addr_in == rfttc_pkg::SYNTH_RX_TEST_ENABLES_OFS) begin
      sel_synth = 1'b1;
    end else if (addr_in == rfttc_pkg::FILTER_CAL_TEST_OFS) begin
      sel_cal = 1'b1;
    end else if (addr_in == rfttc_pkg::XTAL_TEST_CONTROL_OFS) begin
      sel_xtal = 1'b1;
    end
  end

  // Reserved positions are masked on write so they can never reach a block.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      synth_q <= rfttc_pkg::SYNTH_RX_TEST_ENABLES_RST;
    end else if (wr_en_in && sel_synth) begin
      synth_q <= wr_data_in & rfttc_pkg::SYNTH_WRITE_MASK;
    end
  end

  // The manual value is undefined after reset by nature; it is cleared here for determinism.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_q <= rfttc_pkg::FILTER_CAL_TEST_RST;
    end else if (wr_en_in && sel_cal) begin
      cal_q <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xtal_q <= rfttc_pkg::XTAL_TEST_CONTROL_RST;
    end else if (wr_en_in && sel_xtal) begin
      xtal_q <= wr_data_in;
    end
  end

  always_comb begin
    rd_data_d = rfttc_pkg::UNMAPPED_READ_VAL;
    if (sel_synth) begin
      rd_data_d = synth_q;
    end else if (sel_cal) begin
      rd_data_d = cal_q;
    end else if (sel_xtal) begin
      rd_data_d = xtal_q;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= rfttc_pkg::UNMAPPED_READ_VAL;
    end else if (rd_en_in) begin
      rd_data_out <= rd_data_d;
    end
  end

  // Enable outputs are registered copies so every output leaves a flip-flop.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      synth_en_out <= '0;
    end else begin
      synth_en_out.controlled_osc_enable    <= synth_q[rfttc_pkg::SYN_OSC_BIT];
      synth_en_out.divider_enable           <= synth_q[rfttc_pkg::SYN_DIV_BIT];
      synth_en_out.phase_detect_enable      <= synth_q[rfttc_pkg::SYN_PHASE_BIT];
      synth_en_out.synth_clock_enable       <= synth_q[rfttc_pkg::SYN_CLK_BIT];
      synth_en_out.reference_voltage_enable <= synth_q[rfttc_pkg::SYN_VREF_BIT];
      synth_en_out.receiver_enable          <= synth_q[rfttc_pkg::SYN_RX_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filter_cal_inhibit_out <= 1'b0;
      filter_cal_result_out  <= 4'h0;
    end else begin
      filter_cal_inhibit_out <= cal_q[rfttc_pkg::CAL_INHIBIT_BIT];
      filter_cal_result_out  <= cal_q[rfttc_pkg::CAL_MAN_MSB:rfttc_pkg::CAL_MAN_LSB];
    end
  end

  rfttc_cal_ctrl u_cal_ctrl (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .cal_wr_in     (wr_en_in && sel_cal),
    .cal_data_in   (wr_data_in),
    .cal_start_out (filter_cal_start_out),
    .r_shift_out   (filter_cal_r_shift_out)
  );

  // Sink and source are qualified by the enable, so a stray sink bit alone does nothing.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xtal_ctl_out <= '0;
    end else begin
      xtal_ctl_out.xtal_offset_level     <= xtal_q[rfttc_pkg::XO_LEVEL_MSB:rfttc_pkg::XO_LEVEL_LSB];
      xtal_ctl_out.xtal_offset_sink      <= xtal_q[rfttc_pkg::XO_OFFS_EN_BIT] && xtal_q[rfttc_pkg::XO_SINK_BIT];
      xtal_ctl_out.xtal_offset_source    <= xtal_q[rfttc_pkg::XO_OFFS_EN_BIT] && !xtal_q[rfttc_pkg::XO_SINK_BIT];
      xtal_ctl_out.xtal_offset_enable    <= xtal_q[rfttc_pkg::XO_OFFS_EN_BIT];
      xtal_ctl_out.xtal_kick_disable     <= xtal_q[rfttc_pkg::XO_KICK_BIT];
      xtal_ctl_out.xtal_detector_disable <= xtal_q[rfttc_pkg::XO_DET_BIT];
      xtal_ctl_out.xtal_bias_disable     <= xtal_q[rfttc_pkg::XO_BIAS_BIT];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_synth_osc_en : assert property (
    wr_en_in && addr_in == 8'h38 |-> ##2 synth_en_out.controlled_osc_enable == $past(wr_data_in[7], 2))
    else $error("Oscillator enable does not follow bit 7.");

  a_synth_clk_en : assert property (
    wr_en_in && addr_in == 8'h38 ##1 !(wr_en_in && addr_in == 8'h38)
    |=> synth_en_out.synth_clock_enable == $past(wr_data_in[4], 2))
    else $error("Synthesizer clock enable does not follow bit 4.");

  a_rx_chain_en : assert property (
    synth_en_out.receiver_enable == $past(synth_q[1]) && synth_en_out.reference_voltage_enable == $past(synth_q[2]))
    else $error("Receive chain enables mismatch.");

  a_cal_trig_start : assert property (
    wr_en_in && addr_in == 8'h39 && wr_data_in[7:6] == 2'b10 |=> filter_cal_start_out)
    else $error("Calibration trigger did not give a start pulse.");

  // Back-to-back triggers are legal, so the pulse may only repeat when the next write triggers again.
  a_start_one_cycle : assert property (
    filter_cal_start_out && !(wr_en_in && addr_in == 8'h39 && wr_data_in[7]) |=> !filter_cal_start_out)
    else $error("Calibration start pulse lasted more than one cycle.");

  a_cal_inhibit : assert property (
    wr_en_in && addr_in == 8'h39 && wr_data_in[6] |=> !filter_cal_start_out)
    else $error("Inhibited calibration still started.");

  a_cal_shift_m41 : assert property (
    wr_en_in && addr_in == 8'h39 && wr_data_in[5:4] == 2'b11 |=> filter_cal_r_shift_out == 8'shD7)
    else $error("Adjust code 11 did not give minus 4.1 percent.");

  a_cal_manual_val : assert property (
    wr_en_in && addr_in == 8'h39 |-> ##2 filter_cal_result_out == $past(wr_data_in[3:0], 2))
    else $error("Manual calibration value not applied.");

  a_xtal_level : assert property (
    wr_en_in && addr_in == 8'h3A |-> ##2 xtal_ctl_out.xtal_offset_level == $past(wr_data_in[7:5], 2))
    else $error("Offset level does not follow bits 7 to 5.");

  a_xtal_sink_gate : assert property (
    !xtal_ctl_out.xtal_offset_enable |-> !xtal_ctl_out.xtal_offset_sink && !xtal_ctl_out.xtal_offset_source)
    else $error("Offset direction active without enable.");

  a_xtal_disables : assert property (
    {xtal_ctl_out.xtal_kick_disable, xtal_ctl_out.xtal_detector_disable, xtal_ctl_out.xtal_bias_disable}
    == $past(xtal_q[2:0]))
    else $error("Oscillator disable bits mismatch.");

  a_reserved_zero : assert property (
    rd_en_in && addr_in == 8'h38 |=> rd_data_out[3] == 1'b0 && rd_data_out[0] == 1'b0)
    else $error("Reserved synthesizer bits read nonzero.");

  a_unmapped_zero : assert property (
    rd_en_in && !(addr_in inside {8'h38, 8'h39, 8'h3A}) |=> rd_data_out == 8'h00)
    else $error("Unmapped read returned nonzero data.");

  a_synth_mid_en : assert property (
    wr_en_in && addr_in == 8'h38 |-> ##2 synth_en_out.divider_enable == $past(wr_data_in[6], 2)
    && synth_en_out.phase_detect_enable == $past(wr_data_in[5], 2))
    else $error("Divider or phase detector enable does not follow its bit.");

  a_xtal_test_bits : assert property (
    wr_en_in && addr_in == 8'h3A |-> ##2 xtal_ctl_out.xtal_offset_enable == $past(wr_data_in[3], 2)
    && xtal_ctl_out.xtal_kick_disable == $past(wr_data_in[2], 2)
    && xtal_ctl_out.xtal_detector_disable == $past(wr_data_in[1], 2))
    else $error("Oscillator enable or disable bits do not follow the write.");

  a_xtal_sink_dir : assert property (
    xtal_ctl_out.xtal_offset_enable |-> xtal_ctl_out.xtal_offset_sink == $past(xtal_q[4])
    && xtal_ctl_out.xtal_offset_source == !$past(xtal_q[4]))
    else $error("Offset direction does not follow the sink bit.");

  // A read in the same cycle as a write to the same register must return the old contents.
  a_rd_old_value : assert property (
    rd_en_in && wr_en_in && addr_in == 8'h39 |=> rd_data_out == $past(cal_q))
    else $error("Read during write did not return the old value.");

endmodule : rfttc_regs

/* File: verif/rfttc_regs_bench.sv */
// Purpose: Self-checking bench for the receiver test control register bank.
// Assumes: Bench drives on the falling edge; read data is due one cycle after the read strobe.
// Notes:   Reads are noted in a queue and checked by a monitor; level outputs are checked after each write in the register loops.
`timescale 1ns/100ps
module rfttc_regs_bench;
  logic                       clk_in;
  logic                       reset_n_in;
  logic                       wr_en_in;
  logic                       rd_en_in;
  logic [7:0]                 addr_in;
  logic [7:0]                 wr_data_in;
  logic [7:0]                 rd_data_out;
  rfttc_pkg::rfttc_synth_en_t synth_en_out;
  logic                       filter_cal_start_out;
  logic                       filter_cal_inhibit_out;
  logic signed [7:0]          filter_cal_r_shift_out;
  logic [3:0]                 filter_cal_result_out;
  rfttc_pkg::rfttc_xtal_ctl_t xtal_ctl_out;
  int                         failures;
  int                         check_count;
  int                         pulses;
  int                         exp_pulses;
  logic                       rd_seen;
  logic [7:0]                 rd_q[$];
  logic [7:0]                 d;
  logic [7:0]                 sy;
  logic [7:0]                 xt;
  logic signed [7:0]          shift_tab [4];

  rfttc_regs rfttc_regs_i (
    .clk_in                 (clk_in),
    .reset_n_in             (reset_n_in),
    .addr_in                (addr_in),
    .wr_en_in               (wr_en_in),
    .rd_en_in               (rd_en_in),
    .wr_data_in             (wr_data_in),
    .rd_data_out            (rd_data_out),
    .synth_en_out           (synth_en_out),
    .filter_cal_start_out   (filter_cal_start_out),
    .filter_cal_inhibit_out (filter_cal_inhibit_out),
    .filter_cal_r_shift_out (filter_cal_r_shift_out),
    .filter_cal_result_out  (filter_cal_result_out),
    .xtal_ctl_out           (xtal_ctl_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    wr_en_in   = 1'b1;
    addr_in    = a;
    wr_data_in = v;
    @(negedge clk_in);
    wr_en_in   = 1'b0;
    wr_data_in = 8'($urandom);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    rd_en_in = 1'b1;
    addr_in  = a;
    rd_q.push_back(exp);
    @(negedge clk_in);
    rd_en_in = 1'b0;
  endtask : rd

  task automatic settle;
    repeat (2) @(negedge clk_in);
  endtask : settle

  task automatic zeros;
    chk({3'h0, synth_en_out}, 9'h000, "synth enables");
    chk(xtal_ctl_out, 9'h000, "xtal controls");
    chk({1'b0, filter_cal_r_shift_out}, 9'h000, "ref shift");
    chk({4'h0, filter_cal_inhibit_out, filter_cal_result_out}, 9'h000, "cal inhibit and value");
  endtask : zeros

  // Read data is registered, so it is judged at the falling edge after the taking edge.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_seen <= 1'b0;
    end else begin
      rd_seen <= rd_en_in;
    end
  end

  always @(negedge clk_in) begin
    if (rd_seen && rd_q.size() > 0) begin
      chk({1'b0, rd_data_out}, {1'b0, rd_q.pop_front()}, "read data");
    end
    if (filter_cal_start_out === 1'b1) begin
      pulses++;
    end
  end

  initial begin
    #(20 * 20000);
    failures++;
    complete_run();
  end

  initial begin
    shift_tab = '{rfttc_pkg::R_SHIFT_NONE, rfttc_pkg::R_SHIFT_P125, rfttc_pkg::R_SHIFT_M62, rfttc_pkg::R_SHIFT_M41};
    void'($urandom(65));
    reset_n_in = 1'b0;
    wr_en_in   = 1'b0;
    rd_en_in   = 1'b0;
    addr_in    = 8'h00;
    wr_data_in = 8'h00;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    zeros();
    rd(8'h38, 8'h00);
    rd(8'h3A, 8'h00);
    for (int i = 0; i < 6; i++) begin
      sy = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h38, sy);
      settle();
      chk({3'h0, synth_en_out}, {3'h0, sy[7:4], sy[2:1]}, "synth enables");
      rd(8'h38, sy & 8'hF6);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      d[5:4] = 2'(i);
      wr(8'h39, d);
      exp_pulses += int'(d[7] & ~d[6]);
      chk({1'b0, filter_cal_r_shift_out}, {1'b0, shift_tab[i % 4]}, "ref shift");
      settle();
      chk({4'h0, filter_cal_inhibit_out, filter_cal_result_out}, {4'h0, d[6], d[3:0]}, "cal fields");
      rd(8'h39, d);
    end
    // Three writes back to back: trigger, trigger with inhibit, trigger.
    @(negedge clk_in);
    wr_en_in = 1'b1;
    addr_in  = 8'h39;
    wr_data_in = 8'h80;
    @(negedge clk_in);
    wr_data_in = 8'hC0;
    @(negedge clk_in);
    wr_data_in = 8'h80;
    @(negedge clk_in);
    wr_en_in = 1'b0;
    exp_pulses += 2;
    settle();
    chk(9'(pulses), 9'(exp_pulses), "start pulses");
    for (int i = 0; i < 8; i++) begin
      xt = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h3A, xt);
      settle();
      chk(xtal_ctl_out, {xt[7:4] & {3'h7, xt[3]}, xt[3] & ~xt[4], xt[3:0]}, "xtal controls");
      rd(8'h3A, xt);
    end
    wr(8'h3B, 8'hFF);
    wr(8'h37, 8'hFF);
    rd(8'h3B, 8'h00);
    rd(8'h38, sy & 8'hF6);
    rd(8'h3A, xt);
    settle();
    @(negedge clk_in);
    reset_n_in = 1'b0;
    @(negedge clk_in);
    zeros();
    reset_n_in = 1'b1;
    rd(8'h38, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h3A, 8'h00);
    settle();
    chk(9'(rd_q.size()), 9'h000, "reads left unanswered");
    complete_run();
  end
endmodule : rfttc_regs_bench
